// file: dv/tb_top.sv
// Purpose: Self-checking bench for the swap / translate / xor unit
// Assumes: Registers are loaded through the unit's own instructions
// Notes:   Cycle counts measured from take edge to done
`default_nettype none
module tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk_sys_in = 1'b0;
  logic nrst_in = 1'b0;
  logic start_in = 1'b0;
  logic [2:0] dbg_sel = 3'h0;
  logic [3:0] lat = 4'h0;
  xtx_pkg::xtx_instr_t instr = '0;
  xtx_pkg::xtx_bus_t bus;
  xtx_pkg::xtx_flags_t flags;
  logic ack, done, busy, illegal;
  logic [15:0] rdata, dbg, last_addr;
  int fails = 0;
  int samples_checked = 0;
  int cyc = 0;
  int xfers = 0;
  int lock_bad = 0;
  int n;
  always #25 clk_sys_in = ~clk_sys_in;
  xtx_exec xtx_exec_inst (.clk_sys_in(clk_sys_in), .nrst_in(nrst_in), .ce_in(1'b1),
    .start_in(start_in), .instr_in(instr), .mem_ack_in(ack), .mem_rdata_in(rdata),
    .dbg_sel_in(dbg_sel), .bus_out(bus), .busy_out(busy), .done_out(done),
    .illegal_out(illegal), .flags_out(flags), .dbg_word_out(dbg));
  xtx_mem_model xtx_mem_model_inst (.clk_sys_in(clk_sys_in), .bus_in(bus), .lat_in(lat),
    .ack_out(ack), .rdata_out(rdata));
  // ----------------------------------------
  // Monitors
  // ----------------------------------------
  always @(posedge clk_sys_in) begin
    cyc <= cyc + 1;
    if (ack) xfers <= xfers + 1;
    if (ack) last_addr <= bus.addr;
    if (bus.req && !bus.lock && instr.lock) lock_bad <= lock_bad + 1;
    if (cyc == 4000) begin
      fails = fails + 1;
      print_verdict();
    end
  end
  // ----------------------------------------
  // Tasks
  // ----------------------------------------
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      fails++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic run(input logic [7:0] op, input logic [7:0] mr, input logic [15:0] im,
                     input logic lk, input logic [15:0] ea, input logic [7:0] ec);
    @(posedge clk_sys_in);
    start_in <= 1'b1;
    instr <= {op, mr, im, lk, ea, ec};
    xfers = 0;
    @(posedge clk_sys_in);
    start_in <= 1'b0;
    n = 0;
    do begin
      @(posedge clk_sys_in);
      n++;
      #1;
      if (n == 1) check({15'h0000, busy}, 16'h0001);
    end while (done !== 1'b1 && n < 200);
    check({15'h0000, busy}, 16'h0000);
  endtask
  task automatic reg_is(input logic [2:0] idx, input logic [15:0] exp);
    @(posedge clk_sys_in);
    dbg_sel <= idx;
    @(posedge clk_sys_in);
    #1 check(dbg, exp);
  endtask
  task automatic print_verdict();
    $display("checks=%0d mismatches=%0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  // ----------------------------------------
  // Sequence
  // ----------------------------------------
  initial begin
    repeat (2) @(posedge clk_sys_in);
    nrst_in <= 1'b1;
    #1 check(16'(flags), 16'h0000);
    @(posedge clk_sys_in);
    start_in <= 1'b1;
    instr    <= {8'h80, 8'hC3, 16'h0000, 1'b0, 16'h0000, 8'h00};
    @(posedge clk_sys_in);
    start_in <= 1'b0;
    #1 check({15'h0000, illegal}, 16'h0001);
    check({15'h0000, busy}, 16'h0000);
    run(8'h35, 8'h00, 16'h1234, 1'b0, 16'h0000, 8'h00);
    check(16'(n), 16'd4);
    check(16'(flags), 16'h0000);
    reg_is(3'h0, 16'h1234);
    run(8'h93, 8'h00, 16'h0000, 1'b0, 16'h0000, 8'h00);
    check(16'(n), 16'd3);
    reg_is(3'h3, 16'h1234);
    run(8'h34, 8'h00, 16'hABFF, 1'b0, 16'h0000, 8'h00);
    check(16'(flags), 16'h0012);
    reg_is(3'h0, 16'h00FF);
    run(8'h87, 8'hC3, 16'h0000, 1'b0, 16'h0000, 8'h00);
    check(16'(n), 16'd4);
    reg_is(3'h0, 16'h1234);
    reg_is(3'h3, 16'h00FF);
    run(8'h31, 8'hC3, 16'h0000, 1'b0, 16'h0000, 8'h00);
    check(16'(n), 16'd3);
    reg_is(3'h3, 16'h12CB);
    reg_is(3'h0, 16'h1234);
    run(8'h33, 8'hC0, 16'h0000, 1'b0, 16'h0000, 8'h00);
    check(16'(flags), 16'h0014);
    run(8'h81, 8'hF3, 16'h00CB, 1'b0, 16'h0000, 8'h00);
    check(16'(n), 16'd4);
    reg_is(3'h3, 16'h1200);
    xtx_mem_model_inst.mem[8'h05] = 8'h33;
    run(8'h35, 8'h00, 16'h0005, 1'b0, 16'h0000, 8'h00);
    run(8'hD7, 8'h00, 16'h0000, 1'b0, 16'h0000, 8'h00);
    check(16'(n), 16'd11);
    check(last_addr, 16'h1205);
    check(16'(flags), 16'h0010);
    reg_is(3'h0, 16'h0033);
    xtx_mem_model_inst.mem[8'h10] = 8'hAA;
    xtx_mem_model_inst.mem[8'h11] = 8'h55;
    run(8'h87, 8'h06, 16'h0000, 1'b1, 16'h0010, 8'h05);
    check(16'(n), 16'd30);
    check(16'(xfers), 16'd2);
    check(16'(lock_bad), 16'd0);
    check({xtx_mem_model_inst.mem[8'h11], xtx_mem_model_inst.mem[8'h10]}, 16'h0033);
    reg_is(3'h0, 16'h55AA);
    xtx_mem_model_inst.mem[8'h20] = 8'hF0;
    run(8'h30, 8'h06, 16'h0000, 1'b0, 16'h0020, 8'h00);
    check(16'(n), 16'd16);
    check(16'(xtx_mem_model_inst.mem[8'h20]), 16'h005A);
    lat <= 4'h6;
    run(8'h32, 8'h06, 16'h0000, 1'b0, 16'h0020, 8'h00);
    check(16'(xfers), 16'd1);
    reg_is(3'h0, 16'h55F0);
    print_verdict();
  end
endmodule
`default_nettype wire

// file: dv/xtx_mem_model.sv
// Purpose: System memory behind the execution unit's bus port
// Assumes: 256 bytes, low address byte selects the byte
// Notes:   Ack comes lat_in cycles after req is first seen
`default_nettype none
module xtx_mem_model (
  input  wire logic              clk_sys_in,  // Clock
  input  wire xtx_pkg::xtx_bus_t bus_in,      // Request from unit
  input  wire logic [3:0]        lat_in,      // Ack latency
  output logic                   ack_out,     // Transfer complete
  output logic [15:0]            rdata_out    // Read data with ack
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0]  mem [256];
  logic [3:0]  cnt_r;
  logic [15:0] last_r = 16'h0000;
  logic [7:0]  a;
  assign a = bus_in.addr[7:0];
  assign ack_out = bus_in.req && (cnt_r == lat_in);
  // Stale data inverted so a late sample never looks right
  assign rdata_out = ack_out ? {mem[8'(a + 8'h01)], mem[a]} : ~last_r;
  initial cnt_r = 4'h0;
  always @(posedge clk_sys_in) begin
    cnt_r <= (bus_in.req && !ack_out) ? cnt_r + 4'h1 : 4'h0;
    if (ack_out) begin
      last_r <= rdata_out;
      if (bus_in.we) begin
        mem[a] <= bus_in.wdata[7:0];
        if (bus_in.word) mem[8'(a + 8'h01)] <= bus_in.wdata[15:8];
      end
    end
  end
endmodule
`default_nettype wire

// file: verilog/xtx_exec.sv
// Purpose: Decode and execute swap, table translate and exclusive-or
// Assumes: Memory answers each request with one-cycle ack, rdata beside it
// Notes:   Instruction bytes and effective address arrive pre-fetched
//
// What this block does
// [RULE1] Swap exchanges both operands, byte or word
// [RULE2] Locked memory swap keeps bus locked throughout
// [RULE3] 1000011w plus mod-reg-rm decodes general swap
// [RULE4] 10010rrr swaps word register with accumulator
// [RULE5] Swap takes 3, 4, 17/25+address clocks
// [RULE6] Translate loads low accumulator from table
// [RULE7] Table address is base plus low accumulator
// [RULE8] Xor result written back to destination
// [RULE9] 001100dw: direction bit selects destination
// [RULE10] 1000000w with reg 110 is immediate xor
// [RULE11] 0011010w xors immediate into accumulator
// [RULE12] Xor clocks per operand form and transfers
// [RULE13] Xor clears carry/overflow; others keep flags
//
// Local design decisions: the register addresses and the address-and-strobe port.
`default_nettype none
module xtx_exec (
  input  wire logic                clk_sys_in,    // 20 MHz clock
  input  wire logic                nrst_in,       // Sync reset, active low
  input  wire logic                ce_in,         // Clock enable
  input  wire logic                start_in,      // Instruction present
  input  wire xtx_pkg::xtx_instr_t instr_in,      // Instruction fields
  input  wire logic                mem_ack_in,    // Memory transfer complete
  input  wire logic [15:0]         mem_rdata_in,  // Read data with ack
  input  wire logic [2:0]          dbg_sel_in,    // Register to observe
  output xtx_pkg::xtx_bus_t        bus_out,       // Memory request
  output logic                     busy_out,      // Instruction in flight
  output logic                     done_out,      // Instruction finished
  output logic                     illegal_out,   // Opcode not handled
  output xtx_pkg::xtx_flags_t      flags_out,     // Status flags
  output logic [15:0]              dbg_word_out   // Selected register
);
  // ------------------------------------------------------------
  // State
  // ------------------------------------------------------------
  xtx_pkg::xtx_state_t st_r;
  xtx_pkg::xtx_dec_t   dec_c;
  xtx_pkg::xtx_dec_t   op_r;
  xtx_pkg::xtx_instr_t ins_r;
  xtx_pkg::xtx_bus_t   bus_r;
  xtx_pkg::xtx_flags_t flags_r;
  logic [15:0] regs_r   [8];
  logic [15:0] regs_nxt [8];
  logic [15:0] mdata_r;
  logic [8:0]  cyc_r;
  logic        busy_r;
  logic        done_r;
  logic        illegal_r;
  logic [15:0] dbg_r;
  logic        accept;
  logic        wb;
  logic [15:0] regv;
  logic [15:0] eav;
  logic [15:0] immv;
  logic [15:0] lhs;
  logic [15:0] rhs;
  logic [15:0] res;
  logic [15:0] wdata_c;
  logic [15:0] table_lookup_translate_addr;
  logic        pf_c;
  logic        sf_c;
  logic        zf_c;

  function automatic logic [15:0] rd_op(input logic [2:0] idx, input logic w);
    logic [15:0] word;
    word = regs_r[w ? idx : {1'b0, idx[1:0]}];
    if (w) begin
      rd_op = word;
    end else begin
      rd_op = {8'h00, (idx[2] ? word[15:8] : word[7:0])};
    end
  endfunction

  function automatic logic [15:0] merge(input logic [15:0] old, input logic w,
                                        input logic hi, input logic [15:0] val);
    if (w) begin
      merge = val;
    end else if (hi) begin
      merge = {val[7:0], old[7:0]};
    end else begin
      merge = {old[15:8], val[7:0]};
    end
  endfunction

  // ------------------------------------------------------------
  // Decode
  // ------------------------------------------------------------
  always_comb begin
    dec_c         = '0;
    dec_c.kind    = xtx_pkg::KIND_SWAP;
    dec_c.w       = instr_in.opcode[0];
    dec_c.reg_idx = instr_in.modrm[5:3];
    dec_c.rm_idx  = instr_in.modrm[2:0];
    dec_c.mem     = (instr_in.modrm[7:6] != xtx_pkg::MOD_REG);
    if (instr_in.opcode[7:1] == xtx_pkg::OPC_SWAP_RM) begin // [RULE3]
      dec_c.legal  = 1'b1;
      dec_c.d_reg  = 1'b1;
      dec_c.lock   = instr_in.lock & dec_c.mem;
      dec_c.cycles = dec_c.mem ? (dec_c.w ? xtx_pkg::CYC_SWAP_MW : xtx_pkg::CYC_SWAP_MB)
                               : xtx_pkg::CYC_SWAP_RR; // [RULE5]
    end else if (instr_in.opcode[7:3] == xtx_pkg::OPC_SWAP_ACC) begin // [RULE4]
      dec_c.legal   = 1'b1;
      dec_c.w       = 1'b1;
      dec_c.d_reg   = 1'b1;
      dec_c.mem     = 1'b0;
      dec_c.reg_idx = xtx_pkg::IDX_ACC;
      dec_c.rm_idx  = instr_in.opcode[2:0];
      dec_c.cycles  = xtx_pkg::CYC_SWAP_ACC; // [RULE5]
    end else if (instr_in.opcode == xtx_pkg::OPC_TABLE_LOOKUP_TRANSLATE) begin // [RULE7]
      dec_c.legal   = 1'b1;
      dec_c.kind    = xtx_pkg::KIND_TABLE_LOOKUP_TRANSLATE;
      dec_c.w       = 1'b0;
      dec_c.d_reg   = 1'b1;
      dec_c.mem     = 1'b1;
      dec_c.reg_idx = xtx_pkg::IDX_ACC;
      dec_c.cycles  = xtx_pkg::CYC_TABLE_LOOKUP_TRANSLATE;
    end else if (instr_in.opcode[7:2] == xtx_pkg::OPC_XOR_RM) begin // [RULE9]
      dec_c.legal  = 1'b1;
      dec_c.kind   = xtx_pkg::KIND_XOR;
      dec_c.d_reg  = instr_in.opcode[1];
      if (!dec_c.mem) begin
        dec_c.cycles = xtx_pkg::CYC_XOR_RR;
      end else if (dec_c.d_reg) begin
        dec_c.cycles = dec_c.w ? xtx_pkg::CYC_XOR_MSW : xtx_pkg::CYC_XOR_MSB; // [RULE12]
      end else begin
        dec_c.cycles = dec_c.w ? xtx_pkg::CYC_XOR_MDW : xtx_pkg::CYC_XOR_MDB; // [RULE12]
      end
    end else if (instr_in.opcode[7:1] == xtx_pkg::OPC_XOR_IMM &&
                 instr_in.modrm[5:3] == xtx_pkg::OPC_XOR_EXT) begin // [RULE10]
      dec_c.legal  = 1'b1;
      dec_c.kind   = xtx_pkg::KIND_XOR;
      dec_c.imm    = 1'b1;
      dec_c.cycles = dec_c.mem ? (dec_c.w ? xtx_pkg::CYC_XOR_MIW : xtx_pkg::CYC_XOR_MIB)
                               : xtx_pkg::CYC_XOR_IMM; // [RULE12]
    end else if (instr_in.opcode[7:1] == xtx_pkg::OPC_XOR_ACC) begin // [RULE11]
      dec_c.legal   = 1'b1;
      dec_c.kind    = xtx_pkg::KIND_XOR;
      dec_c.imm     = 1'b1;
      dec_c.d_reg   = 1'b1;
      dec_c.mem     = 1'b0;
      dec_c.reg_idx = xtx_pkg::IDX_ACC;
      dec_c.cycles  = xtx_pkg::CYC_XOR_IMM;
    end
    if (dec_c.mem && dec_c.kind != xtx_pkg::KIND_TABLE_LOOKUP_TRANSLATE) begin
      dec_c.cycles = dec_c.cycles + {1'b0, instr_in.ea_clocks};
    end
  end

  assign accept = ce_in && start_in && (st_r == xtx_pkg::ST_IDLE);
  assign wb     = ce_in && (st_r == xtx_pkg::ST_CNT) && (cyc_r == 9'd0);

  // ------------------------------------------------------------
  // Datapath
  // ------------------------------------------------------------
  // Process form, so register reads inside the function re-trigger it
  always_comb begin
    regv = rd_op(op_r.reg_idx, op_r.w);
    eav  = op_r.mem ? mdata_r : rd_op(op_r.rm_idx, op_r.w);
  end
  assign immv      = op_r.w ? ins_r.imm : {8'h00, ins_r.imm[7:0]}; // [RULE10]
  assign lhs       = op_r.d_reg ? regv : eav;
  assign rhs       = op_r.imm ? immv : (op_r.d_reg ? eav : regv);
  assign res       = lhs ^ rhs; // [RULE8]
  assign wdata_c   = (op_r.kind == xtx_pkg::KIND_SWAP) ? regv : res;
  // Address wraps within 16 bits like any offset sum
  assign table_lookup_translate_addr = regs_r[xtx_pkg::IDX_BASE] + {8'h00, regs_r[xtx_pkg::IDX_ACC][7:0]}; // [RULE7]

  xtx_flag_calc u_flags (
    .res_in (res),
    .w_in   (op_r.w),
    .pf_out (pf_c),
    .sf_out (sf_c),
    .zf_out (zf_c)
  );

  // ------------------------------------------------------------
  // Register file update
  // ------------------------------------------------------------
  // Both targets read old values, so a swap of two halves of one register works
  always_comb begin
    logic [2:0] t;
    t = 3'h0;
    for (int i = 0; i < 8; i++) begin
      regs_nxt[i] = regs_r[i];
    end
    if (wb) begin
      case (op_r.kind)
        xtx_pkg::KIND_SWAP: begin
          t = op_r.w ? op_r.reg_idx : {1'b0, op_r.reg_idx[1:0]};
          regs_nxt[t] = merge(regs_nxt[t], op_r.w, op_r.reg_idx[2], eav); // [RULE1]
          if (!op_r.mem) begin
            t = op_r.w ? op_r.rm_idx : {1'b0, op_r.rm_idx[1:0]};
            regs_nxt[t] = merge(regs_nxt[t], op_r.w, op_r.rm_idx[2], regv); // [RULE1]
          end
        end
        xtx_pkg::KIND_TABLE_LOOKUP_TRANSLATE: begin
          regs_nxt[xtx_pkg::IDX_ACC] = merge(regs_nxt[xtx_pkg::IDX_ACC], 1'b0, 1'b0,
                                             mdata_r); // [RULE6]
        end
        xtx_pkg::KIND_XOR: begin
          if (op_r.d_reg) begin
            t = op_r.w ? op_r.reg_idx : {1'b0, op_r.reg_idx[1:0]};
            regs_nxt[t] = merge(regs_nxt[t], op_r.w, op_r.reg_idx[2], res); // [RULE8]
          end else if (!op_r.mem) begin
            t = op_r.w ? op_r.rm_idx : {1'b0, op_r.rm_idx[1:0]};
            regs_nxt[t] = merge(regs_nxt[t], op_r.w, op_r.rm_idx[2], res); // [RULE8]
          end
        end
        default: begin
          t = 3'h0;
        end
      endcase
    end
  end

  always_ff @(posedge clk_sys_in) begin
    if (!nrst_in) begin
      for (int i = 0; i < 8; i++) begin
        regs_r[i] <= xtx_pkg::REG_RST;
      end
    end else if (ce_in) begin
      for (int i = 0; i < 8; i++) begin
        regs_r[i] <= regs_nxt[i];
      end
    end
  end

  // ------------------------------------------------------------
  // Sequencer and memory bus
  // ------------------------------------------------------------
  always_ff @(posedge clk_sys_in) begin
    if (!nrst_in) begin
      st_r    <= xtx_pkg::ST_IDLE;
      op_r    <= '0;
      ins_r   <= '0;
      bus_r   <= xtx_pkg::BUS_RST;
      mdata_r <= xtx_pkg::REG_RST;
      cyc_r   <= xtx_pkg::CYC_RST;
    end else if (ce_in) begin
      if (cyc_r != 9'd0) begin
        cyc_r <= cyc_r - 9'd1;
      end
      case (st_r)
        xtx_pkg::ST_IDLE: begin
          if (accept && dec_c.legal) begin
            op_r  <= dec_c;
            ins_r <= instr_in;
            cyc_r <= dec_c.cycles - 9'd1;
            if (dec_c.mem) begin
              st_r       <= xtx_pkg::ST_RD;
              bus_r.req  <= 1'b1;
              bus_r.we   <= 1'b0;
              bus_r.word <= dec_c.w;
              bus_r.lock <= dec_c.lock; // [RULE2]
              bus_r.addr <= (dec_c.kind == xtx_pkg::KIND_TABLE_LOOKUP_TRANSLATE) ? table_lookup_translate_addr
                                                                : instr_in.ea_addr;
            end else begin
              st_r <= xtx_pkg::ST_CNT;
            end
          end
        end
        xtx_pkg::ST_RD: begin
          if (mem_ack_in) begin
            bus_r.req <= 1'b0;
            mdata_r   <= op_r.w ? mem_rdata_in : {8'h00, mem_rdata_in[7:0]};
            // Register-destination forms need only the one transfer
            if (op_r.kind == xtx_pkg::KIND_SWAP ||
                (op_r.kind == xtx_pkg::KIND_XOR && !op_r.d_reg)) begin
              st_r <= xtx_pkg::ST_WR;
            end else begin
              st_r <= xtx_pkg::ST_CNT;
            end
          end
        end
        xtx_pkg::ST_WR: begin
          if (!bus_r.req) begin
            bus_r.req   <= 1'b1;
            bus_r.we    <= 1'b1;
            bus_r.wdata <= wdata_c; // [RULE1]
          end else if (mem_ack_in) begin
            bus_r.req  <= 1'b0;
            bus_r.we   <= 1'b0;
            bus_r.lock <= 1'b0; // [RULE2]
            st_r       <= xtx_pkg::ST_CNT;
          end
        end
        xtx_pkg::ST_CNT: begin
          if (cyc_r == 9'd0) begin
            st_r <= xtx_pkg::ST_IDLE;
          end
        end
        default: begin
          st_r <= xtx_pkg::ST_IDLE;
        end
      endcase
    end
  end

  // ------------------------------------------------------------
  // Flags and status outputs
  // ------------------------------------------------------------
  // Auxiliary carry is left as it was: undefined after xor
  always_ff @(posedge clk_sys_in) begin
    if (!nrst_in) begin
      flags_r <= xtx_pkg::FLAGS_RST;
    end else if (wb && op_r.kind == xtx_pkg::KIND_XOR) begin
      flags_r.cf <= 1'b0; // [RULE13]
      flags_r.of <= 1'b0; // [RULE13]
      flags_r.pf <= pf_c;
      flags_r.sf <= sf_c;
      flags_r.zf <= zf_c;
    end
  end

  always_ff @(posedge clk_sys_in) begin
    if (!nrst_in) begin
      busy_r    <= 1'b0;
      done_r    <= 1'b0;
      illegal_r <= 1'b0;
      dbg_r     <= xtx_pkg::REG_RST;
    end else if (ce_in) begin
      done_r    <= wb;
      illegal_r <= accept && !dec_c.legal;
      busy_r    <= (accept && dec_c.legal) || (busy_r && !wb);
      dbg_r     <= regs_nxt[dbg_sel_in];
    end
  end

  assign bus_out      = bus_r;
  assign busy_out     = busy_r;
  assign done_out     = done_r;
  assign illegal_out  = illegal_r;
  assign flags_out    = flags_r;
  assign dbg_word_out = dbg_r;

  // ------------------------------------------------------------
  // Checks
  // ------------------------------------------------------------
  logic [9:0]  run_cnt;
  logic [15:0] res_seen;
  always_ff @(posedge clk_sys_in) begin
    if (!nrst_in) begin
      run_cnt  <= 10'd0;
      res_seen <= 16'h0000;
    end else if (ce_in) begin
      run_cnt  <= accept ? 10'd0 : (busy_r ? run_cnt + 10'd1 : run_cnt);
      res_seen <= wb ? res : res_seen;
    end
  end

  default clocking cb @(posedge clk_sys_in); endclocking
  default disable iff (!nrst_in);

  sequence s_wr_done;
    bus_r.req && bus_r.we && mem_ack_in && ce_in;
  endsequence

  a_lock_release: assert property (s_wr_done ##1 1'b1 |-> !bus_r.lock) // [RULE2]
    else $error("lock still held after locked write");
  a_lock_to_write: assert property ($rose(bus_r.lock) |-> bus_r.req && !bus_r.we) // [RULE2]
    else $error("lock raised without a read");
  a_swap_decode: assert property (accept && instr_in.opcode[7:1] == 7'b100_0011 // [RULE3]
    |=> op_r.kind == xtx_pkg::KIND_SWAP && busy_r)
    else $error("general swap not decoded");
  a_short_swap: assert property (accept && instr_in.opcode[7:3] == 5'b1_0010 // [RULE4]
    |=> op_r.w && op_r.reg_idx == 3'h0 && op_r.rm_idx == $past(instr_in.opcode[2:0]))
    else $error("short swap operands wrong");
  // Short form and register pair differ by one clock; only the opcode tells them apart
  a_swap_clocks: assert property (done_r && op_r.kind == xtx_pkg::KIND_SWAP // [RULE5]
    && !op_r.mem |-> run_cnt == (ins_r.opcode[7:3] == 5'b1_0010 ? 10'd3 : 10'd4))
    else $error("register swap clock count wrong");
  a_table_load: assert property (wb && op_r.kind == xtx_pkg::KIND_TABLE_LOOKUP_TRANSLATE // [RULE6]
    |=> regs_r[0][7:0] == $past(mdata_r[7:0]))
    else $error("translate did not load table byte");
  a_table_addr: assert property ($rose(bus_r.req) && op_r.kind == xtx_pkg::KIND_TABLE_LOOKUP_TRANSLATE // [RULE7]
    |-> bus_r.addr == table_lookup_translate_addr)
    else $error("table address not base plus index");
  a_xor_reg_clk: assert property (done_r && op_r.kind == xtx_pkg::KIND_XOR // [RULE12]
    && !op_r.mem |-> run_cnt == (op_r.imm ? 10'd4 : 10'd3))
    else $error("register xor clock count wrong");
  a_dir_bit: assert property (accept && instr_in.opcode[7:2] == 6'b00_1100 // [RULE9]
    |=> op_r.d_reg == $past(instr_in.opcode[1]))
    else $error("xor direction bit ignored");
  a_imm_ext: assert property (accept && instr_in.opcode[7:1] == 7'b100_0000 // [RULE10]
    && instr_in.modrm[5:3] != 3'b110 |=> illegal_r)
    else $error("immediate form with wrong reg field accepted");
  a_acc_xor: assert property (accept && instr_in.opcode[7:1] == 7'b001_1010 // [RULE11]
    |=> op_r.imm && op_r.d_reg && op_r.reg_idx == 3'h0)
    else $error("accumulator xor routed wrong");
  // Stored word against a differ-bit formula, not the datapath's own xor
  a_xor_result: assert property (wb && op_r.kind == xtx_pkg::KIND_XOR && op_r.d_reg // [RULE8]
    && op_r.w |=> regs_r[$past(op_r.reg_idx)] == $past((lhs | rhs) & ~(lhs & rhs)))
    else $error("xor result bit wrong");
  a_xor_flags: assert property (done_r && $past(op_r.kind) == xtx_pkg::KIND_XOR // [RULE13]
    |-> !flags_r.cf && !flags_r.of && flags_r.zf == (op_r.w ? res_seen == 16'h0000
        : res_seen[7:0] == 8'h00))
    else $error("xor flags wrong");
  a_flags_kept: assert property (done_r && op_r.kind != xtx_pkg::KIND_XOR // [RULE13]
    |-> $stable(flags_r))
    else $error("flags changed by swap or translate");
endmodule
`default_nettype wire

// file: verilog/xtx_flag_calc.sv
// Purpose: Parity, sign and zero of a byte or word result
// Assumes: Parity looks at the low byte only
// Notes:   Purely combinational
`default_nettype none
module xtx_flag_calc (
  input  wire logic [15:0] res_in,   // Result value
  input  wire logic        w_in,     // Word width
  output logic             pf_out,   // Even number of ones in low byte
  output logic             sf_out,   // Top bit of result
  output logic             zf_out    // Result is zero
);
  assign pf_out = ~^res_in[7:0];
  assign sf_out = w_in ? res_in[15] : res_in[7];
  assign zf_out = w_in ? (res_in == 16'h0000) : (res_in[7:0] == 8'h00);
endmodule
`default_nettype wire

// file: verilog/xtx_pkg.sv
// Purpose: Shared types and constants for the swap / translate / xor execution unit
// Assumes: 16-bit registers, 16-bit effective addresses formed outside the unit
// Notes:   Cycle counts are processor clocks at 20 MHz (50 ns)
`default_nettype none
package xtx_pkg;
  // ------------------------------------------------------------
  // Opcode patterns
  // ------------------------------------------------------------
  localparam logic [6:0] OPC_SWAP_RM   = 7'b100_0011;  // 1000011w
  localparam logic [4:0] OPC_SWAP_ACC  = 5'b1_0010;    // 10010rrr
  localparam logic [7:0] OPC_TABLE_LOOKUP_TRANSLATE      = 8'hD7;        // 11010111
  localparam logic [5:0] OPC_XOR_RM    = 6'b00_1100;   // 001100dw
  localparam logic [6:0] OPC_XOR_IMM   = 7'b100_0000;  // 1000000w
  localparam logic [2:0] OPC_XOR_EXT   = 3'b110;       // reg field of immediate form
  localparam logic [6:0] OPC_XOR_ACC   = 7'b001_1010;  // 0011010w
  localparam logic [1:0] MOD_REG       = 2'b11;

  // ------------------------------------------------------------
  // Register indices and reset values
  // ------------------------------------------------------------
  localparam logic [2:0]  IDX_ACC      = 3'h0;
  localparam logic [2:0]  IDX_BASE     = 3'h3;
  localparam logic [15:0] REG_RST      = 16'h0000;
  localparam logic [8:0]  CYC_RST      = 9'h000;

  // ------------------------------------------------------------
  // Clock counts (byte / word)
  // ------------------------------------------------------------
  localparam logic [8:0] CYC_SWAP_ACC  = 9'd3;
  localparam logic [8:0] CYC_SWAP_RR   = 9'd4;
  localparam logic [8:0] CYC_SWAP_MB   = 9'd17;
  localparam logic [8:0] CYC_SWAP_MW   = 9'd25;
  localparam logic [8:0] CYC_TABLE_LOOKUP_TRANSLATE      = 9'd11;
  localparam logic [8:0] CYC_XOR_RR    = 9'd3;
  localparam logic [8:0] CYC_XOR_IMM   = 9'd4;
  localparam logic [8:0] CYC_XOR_MDB   = 9'd16;
  localparam logic [8:0] CYC_XOR_MDW   = 9'd24;
  localparam logic [8:0] CYC_XOR_MIB   = 9'd17;
  localparam logic [8:0] CYC_XOR_MIW   = 9'd25;
  localparam logic [8:0] CYC_XOR_MSB   = 9'd9;
  localparam logic [8:0] CYC_XOR_MSW   = 9'd13;

  typedef enum logic [2:0] {
    KIND_SWAP = 3'b001,
    KIND_TABLE_LOOKUP_TRANSLATE = 3'b010,
    KIND_XOR  = 3'b100
  } xtx_kind_t;

  typedef enum logic [3:0] {
    ST_IDLE = 4'b0001,
    ST_RD   = 4'b0010,
    ST_WR   = 4'b0100,
    ST_CNT  = 4'b1000
  } xtx_state_t;

  typedef struct packed {
    logic [7:0]  opcode;
    logic [7:0]  modrm;
    logic [15:0] imm;        // Low byte first immediate byte
    logic        lock;       // Bus lock prefix seen
    logic [15:0] ea_addr;    // Effective address of memory operand
    logic [7:0]  ea_clocks;  // Address calculation time
  } xtx_instr_t;

  typedef struct packed {
    logic        legal;
    xtx_kind_t   kind;
    logic        w;
    logic        d_reg;      // Result lands in the reg-field register
    logic        mem;
    logic        imm;
    logic        lock;
    logic [2:0]  reg_idx;
    logic [2:0]  rm_idx;
    logic [8:0]  cycles;
  } xtx_dec_t;

  typedef struct packed {
    logic        req;
    logic        we;
    logic        word;
    logic        lock;
    logic [15:0] addr;
    logic [15:0] wdata;
  } xtx_bus_t;

  typedef struct packed {
    logic cf;
    logic pf;
    logic af;
    logic zf;
    logic sf;
    logic of;
  } xtx_flags_t;

  localparam xtx_flags_t FLAGS_RST = '0;
  localparam xtx_bus_t   BUS_RST   = '0;
endpackage
`default_nettype wire
